/* rtl/scibu_alu.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scibu_consts.svh"

module scibu_alu
  import scibu_pkg::*;
(
  // Instruction and operands, stk[0] is A
  input wire logic [15:0] op,
  input wire scibu_word_t [7:0] stk,
  input wire scibu_word_t [7:0] regs,
  input wire logic [63:0] cvt_fp,
  // Stack effect
  output scibu_res_t res
);

  wire logic [7:0] imm = op[7:0];
  wire scibu_word_t imm_sx = {{8{imm[7]}}, imm};
  wire scibu_word_t imm_left_sx = {imm, {8{imm[7]}}};
  wire scibu_word_t or_imm = op[`SCIBU_OR_LEFT_BIT] ? {imm, 8'h00} : {8'h00, imm};
  wire logic [12:0] grp13 = op[15:3];
  wire logic [6:0] grp7 = op[15:9];
  wire logic [2:0] sel = op[2:0];
  wire logic [2:0] xfld = op[11:9];
  wire scibu_word_t a = stk[0];
  wire scibu_word_t b = stk[1];
  wire scibu_word_t c = stk[2];
  wire scibu_word_t d = stk[3];
  wire scibu_word_t merged = (b & c) | (~b & a);

  always_comb begin
    res = '0;
    res.cc = SCIBU_CC_EQUAL;
    case (op)
      `SCIBU_OP_DTF_TRUNC, `SCIBU_OP_DTF_ROUND: begin
        res.pop_cnt = 4'd2; // [RULE_01]
        res.push_cnt = 3'd2;
        res.word[1:0] = cvt_fp[31:0];
      end
      `SCIBU_OP_QTF_TRUNC, `SCIBU_OP_QTF_ROUND: begin
        res.pop_cnt = 4'd4; // [RULE_02]
        res.push_cnt = 3'd2;
        res.word[1:0] = cvt_fp[31:0];
      end
      `SCIBU_OP_ITE, `SCIBU_OP_DTE: begin
        res.pop_cnt = (op == `SCIBU_OP_ITE) ? 4'd1 : 4'd2; // [RULE_03]
        res.push_cnt = 3'd4;
        res.word = cvt_fp;
      end
      `SCIBU_OP_QTE_TRUNC, `SCIBU_OP_QTE_ROUND: begin
        res.pop_cnt = 4'd4; // [RULE_04]
        res.push_cnt = 3'd4;
        res.word = cvt_fp;
      end
      `SCIBU_OP_SWAP_W: begin
        res.pop_cnt = 4'd2;
        res.push_cnt = 3'd2;
        res.word[1:0] = {a, b}; // [RULE_10]
        res.cc_we = 1'b1;
        res.cc = scibu_cc_word(b); // [RULE_23]
      end
      `SCIBU_OP_SWAP_D: begin
        res.pop_cnt = 4'd4;
        res.push_cnt = 3'd4;
        res.word = {b, a, d, c}; // [RULE_11]
        res.cc_we = 1'b1;
        res.cc = scibu_cc_dbl(d, c);
      end
      `SCIBU_OP_DUP_D: begin
        res.push_cnt = 3'd2;
        res.word[1:0] = {b, a}; // [RULE_12]
        res.cc_we = 1'b1;
        res.cc = scibu_cc_dbl(b, a);
      end
      `SCIBU_OP_AND, `SCIBU_OP_OR, `SCIBU_OP_XOR: begin
        res.pop_cnt = 4'd2;
        res.push_cnt = 3'd1;
        res.word[0] = (op == `SCIBU_OP_AND) ? (a & b) :
                      (op == `SCIBU_OP_OR) ? (a | b) : (a ^ b); // [RULE_17]
        res.cc_we = 1'b1;
        res.cc = scibu_cc_word(res.word[0]);
      end
      `SCIBU_OP_NOT: begin
        res.pop_cnt = 4'd1;
        res.push_cnt = 3'd1;
        res.word[0] = ~a; // [RULE_18]
        res.cc_we = 1'b1;
        res.cc = scibu_cc_word(~a);
      end
      `SCIBU_OP_MERGE: begin
        res.pop_cnt = 4'd3;
        res.push_cnt = 3'd1;
        res.word[0] = merged; // [RULE_22]
        res.cc_we = 1'b1;
        res.cc = scibu_cc_word(merged);
      end
      default: begin
        if (grp13 == `SCIBU_PAT_STORE_POP || grp13 == `SCIBU_PAT_STORE_KEEP) begin
          res.reg_we = 1'b1; // [RULE_13]
          res.reg_sel = sel;
          res.reg_wdata = a;
          res.pop_cnt = (grp13 == `SCIBU_PAT_STORE_POP) ? 4'd1 : 4'd0;
        end else if (grp13 == `SCIBU_PAT_PUSH_REG) begin
          res.push_cnt = 3'd1;
          res.word[0] = regs[sel]; // [RULE_14]
          res.cc_we = 1'b1;
          res.cc = scibu_cc_word(regs[sel]);
        end else if (op[15:12] == `SCIBU_PAT_LOAD_IMM) begin
          res.cc_we = 1'b1; // [RULE_15]
          res.cc = scibu_cc_word(imm_sx);
          if (xfld == 3'h0) begin
            res.push_cnt = 3'd1;
            res.word[0] = imm_sx;
          end else begin
            res.reg_we = 1'b1;
            res.reg_sel = xfld;
            res.reg_wdata = imm_sx;
          end
        end else if (grp7 == `SCIBU_PAT_LEFT_IMM) begin
          res.push_cnt = 3'd1;
          res.word[0] = imm_left_sx; // [RULE_16]
          res.cc_we = 1'b1;
          res.cc = scibu_cc_word(imm_left_sx);
        end else if (grp7 == `SCIBU_PAT_OR_IMM) begin
          res.pop_cnt = 4'd1;
          res.push_cnt = 3'd1;
          res.word[0] = a | or_imm; // [RULE_19]
          res.cc_we = 1'b1;
          res.cc = scibu_cc_word(a | or_imm);
        end else if (grp7 == `SCIBU_PAT_AND_R_IMM) begin
          res.pop_cnt = 4'd1;
          res.push_cnt = 3'd1;
          res.word[0] = a & imm_sx; // [RULE_20]
          res.cc_we = 1'b1;
          res.cc = scibu_cc_word(a & imm_sx);
        end else if (grp7 == `SCIBU_PAT_AND_L_IMM) begin
          res.pop_cnt = 4'd1;
          res.push_cnt = 3'd1;
          res.word[0] = a & imm_left_sx; // [RULE_21]
          res.cc_we = 1'b1;
          res.cc = scibu_cc_word(a & imm_left_sx);
        end else begin
          res.unsup = 1'b1;
        end
      end
    endcase
  end

endmodule

`default_nettype wire

/* rtl/scibu_consts.svh */
`ifndef SCIBU_CONSTS_SVH
`define SCIBU_CONSTS_SVH

// ****************************************
// Exact opcodes
// ****************************************
`define SCIBU_OP_DTF_TRUNC 16'h00c6
`define SCIBU_OP_DTF_ROUND 16'h00d6
`define SCIBU_OP_QTF_TRUNC 16'h00d4
`define SCIBU_OP_QTF_ROUND 16'h00d8
`define SCIBU_OP_ITE 16'h00da
`define SCIBU_OP_DTE 16'h00dc
`define SCIBU_OP_QTE_TRUNC 16'h00de
`define SCIBU_OP_QTE_ROUND 16'h00dd
`define SCIBU_OP_INDEX_ONE_DIM 16'h00e4
`define SCIBU_OP_INDEX_TWO_DIM 16'h00e5
`define SCIBU_OP_INDEX_THREE_DIM 16'h00e6
`define SCIBU_OP_IDXN_CODE 16'h00e7
`define SCIBU_OP_IDXN_DATA 16'h00cf
`define SCIBU_OP_SWAP_W 16'h0004
`define SCIBU_OP_SWAP_D 16'h0005
`define SCIBU_OP_DUP_D 16'h0006
`define SCIBU_OP_AND 16'h0008
`define SCIBU_OP_OR 16'h0009
`define SCIBU_OP_XOR 16'h000a
`define SCIBU_OP_NOT 16'h000b
`define SCIBU_OP_MERGE 16'h000c

// ****************************************
// Opcode patterns (op[15:3], op[15:9], op[15:12])
// ****************************************
`define SCIBU_PAT_STORE_POP 13'h0009
`define SCIBU_PAT_STORE_KEEP 13'h000a
`define SCIBU_PAT_PUSH_REG 13'h000b
`define SCIBU_PAT_OR_IMM 7'h04
`define SCIBU_PAT_LEFT_IMM 7'h05
`define SCIBU_PAT_AND_R_IMM 7'h06
`define SCIBU_PAT_AND_L_IMM 7'h07
`define SCIBU_PAT_LOAD_IMM 4'h8
`define SCIBU_OR_LEFT_BIT 8

// ****************************************
// Number formats, registers, limits
// ****************************************
`define SCIBU_EXP_BIAS 9'h100
`define SCIBU_FLT_SIG 23
`define SCIBU_EXT_SIG 55
`define SCIBU_IDX_REG 3'h7
`define SCIBU_MAX_DIMS 7
`define SCIBU_CC_LESS 2'h1
`define SCIBU_CC_EQUAL 2'h2
`define SCIBU_CC_GREATER 2'h3

`endif

/* rtl/scibu_cvt.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scibu_consts.svh"

// Signed integer to float (32 bit) or extended (64 bit), sign/fraction/exponent
module scibu_cvt (
  // Operand and mode
  input wire logic [63:0] val,
  input wire logic ext,
  input wire logic rnd,
  // Result, float in the low 32 bits
  output logic [63:0] fp
);

  function automatic logic [5:0] msb_pos(input logic [63:0] v);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < 64; i++) begin
      if (v[i]) begin
        p = 6'(i);
      end
    end
    return p;
  endfunction

  // The most negative quad still yields the right magnitude as unsigned
  wire logic sign = val[63];
  wire logic [63:0] mag = sign ? 64'(-val) : val;
  wire logic [5:0] pos = msb_pos(mag);
  wire logic [63:0] norm = mag << (6'h3f - pos);

  // Round on the first dropped bit; a carry out renormalises
  wire logic [23:0] f_mant = {1'b0, norm[63:64-`SCIBU_FLT_SIG]} +
                             24'(rnd & norm[63-`SCIBU_FLT_SIG]);
  wire logic [55:0] e_mant = {1'b0, norm[63:64-`SCIBU_EXT_SIG]} +
                             56'(rnd & norm[63-`SCIBU_EXT_SIG]);
  wire logic f_cy = f_mant[23];
  wire logic e_cy = e_mant[55];
  wire logic [8:0] f_exp = `SCIBU_EXP_BIAS + 9'(pos) + 9'(f_cy);
  wire logic [8:0] e_exp = `SCIBU_EXP_BIAS + 9'(pos) + 9'(e_cy);
  wire logic [21:0] f_frac = f_cy ? 22'h000000 : f_mant[21:0];
  wire logic [53:0] e_frac = e_cy ? 54'h0 : e_mant[53:0];
  wire logic [63:0] f_word = {32'h00000000, sign, f_frac, f_exp};
  wire logic [63:0] e_word = {sign, e_frac, e_exp};

  assign fp = (mag == 64'h0) ? 64'h0 : (ext ? e_word : f_word);

endmodule

`default_nettype wire

/* rtl/scibu_pkg.sv */
`include "scibu_consts.svh"

package scibu_pkg;

  typedef logic [15:0] scibu_word_t;

  typedef enum logic [1:0] {
    SCIBU_CC_LESS = `SCIBU_CC_LESS,
    SCIBU_CC_EQUAL = `SCIBU_CC_EQUAL,
    SCIBU_CC_GREATER = `SCIBU_CC_GREATER
  } scibu_cc_t;

  typedef enum logic [3:0] {
    SCIBU_ST_IDLE = 4'b0001,
    SCIBU_ST_CNT = 4'b0010,
    SCIBU_ST_LO = 4'b0100,
    SCIBU_ST_HI = 4'b1000
  } scibu_state_t;

  // Stack effect of one instruction; word[0] becomes the new A
  typedef struct packed {
    logic [3:0] pop_cnt;
    logic [2:0] push_cnt;
    scibu_word_t [3:0] word;
    logic cc_we;
    scibu_cc_t cc;
    logic ovf;
    logic reg_we;
    logic [2:0] reg_sel;
    scibu_word_t reg_wdata;
    logic unsup;
  } scibu_res_t;

  function automatic scibu_cc_t scibu_cc_word(input scibu_word_t v);
    scibu_cc_t c;
    c = v[15] ? SCIBU_CC_LESS : (v == 16'h0000) ? SCIBU_CC_EQUAL : SCIBU_CC_GREATER;
    return c;
  endfunction

  function automatic scibu_cc_t scibu_cc_dbl(input scibu_word_t hi, input scibu_word_t lo);
    scibu_cc_t c;
    c = hi[15] ? SCIBU_CC_LESS : ({hi, lo} == 32'h0) ? SCIBU_CC_EQUAL : SCIBU_CC_GREATER;
    return c;
  endfunction

endpackage

/* rtl/scibu_top.sv */
//
// Function
// RULE_01: Double in BA becomes float in BA; one opcode truncates, one rounds.
// RULE_02: Quad DCBA popped, two-word float pushed; truncating and rounding forms.
// RULE_03: Single A or double BA popped, four-word extended result pushed.
// RULE_04: Quad DCBA replaced in place by extended value, truncated or rounded.
// RULE_05: One-dimension index checks B against code table at A, removes BA.
// RULE_06: Two and three dimension index check B,C(,D), then remove operands.
// RULE_07: Out-of-bounds subscript sets overflow, goes to R7, less or greater code.
// RULE_08: All subscripts in bounds: element offset written to R7.
// RULE_09: N-dimension index reads count first, code or data table, pops all used.
// RULE_10: Swap A and B, condition code from new A.
// RULE_11: Swap doubles DC and BA, condition code from new BA.
// RULE_12: Push copy of top double, set condition code.
// RULE_13: Store A into selected register; one pattern pops A, one keeps it.
// RULE_14: Push selected register onto the stack, set condition code.
// RULE_15: Push sign-extended immediate, or load it into index register x.
// RULE_16: Immediate shifted left eight, low byte sign-filled, pushed as A.
// RULE_17: Pop A and B, push AND, OR or XOR, set code.
// RULE_18: Replace A by its one's complement, set code.
// RULE_19: OR 8-bit immediate into A, right or left byte, no sign fill.
// RULE_20: Sign-extend immediate to 16 bits, AND into A.
// RULE_21: Immediate shifted left, low byte sign-filled, AND into A.
// RULE_22: Pop A,B,C, push (B and C) or (not B and A).
// RULE_23: Condition code is less, equal or greater by result sign and zero.
//
`timescale 1ns/10ps
`default_nettype none
`include "scibu_consts.svh"

module scibu_top
  import scibu_pkg::*;
#(
  parameter int MAX_DIMS = `SCIBU_MAX_DIMS
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Instruction from the sequencer
  input wire logic start,
  input wire logic [15:0] op,
  input wire scibu_word_t [7:0] stk,
  input wire scibu_word_t [7:0] regs,
  // Completion
  output logic busy,
  output logic done,
  output scibu_res_t res,
  // Bounds table memory port
  output logic mem_req,
  output logic mem_code,
  output scibu_word_t mem_addr,
  input wire logic mem_ack,
  input wire scibu_word_t mem_rdata
);

  // ****************************************
  // Elaboration check
  // ****************************************
  // Subscripts come from B..H, so at most seven dimensions fit the stack
  generate
    if (MAX_DIMS < 1 || MAX_DIMS > 7) begin : g_bad_dims
      $error("MAX_DIMS must lie between 1 and 7");
    end
  endgenerate

  // ****************************************
  // Opcode decode
  // ****************************************
  wire logic op_dtf = (op == `SCIBU_OP_DTF_TRUNC) || (op == `SCIBU_OP_DTF_ROUND);
  wire logic op_qtf = (op == `SCIBU_OP_QTF_TRUNC) || (op == `SCIBU_OP_QTF_ROUND);
  wire logic op_qte = (op == `SCIBU_OP_QTE_TRUNC) || (op == `SCIBU_OP_QTE_ROUND);
  wire logic op_ite = (op == `SCIBU_OP_ITE);
  wire logic op_dte = (op == `SCIBU_OP_DTE);
  wire logic op_rnd = (op == `SCIBU_OP_DTF_ROUND) || (op == `SCIBU_OP_QTF_ROUND) ||
                      (op == `SCIBU_OP_QTE_ROUND);
  wire logic op_index_one_dim = (op == `SCIBU_OP_INDEX_ONE_DIM);
  wire logic op_index_two_dim = (op == `SCIBU_OP_INDEX_TWO_DIM);
  wire logic op_index_three_dim = (op == `SCIBU_OP_INDEX_THREE_DIM);
  wire logic op_idxc = (op == `SCIBU_OP_IDXN_CODE);
  wire logic op_index_n_dim_data = (op == `SCIBU_OP_IDXN_DATA);
  wire logic op_idxn = op_idxc || op_index_n_dim_data;
  wire logic op_idx = op_index_one_dim || op_index_two_dim || op_index_three_dim || op_idxn;
  wire logic [2:0] fixed_dims = op_index_one_dim ? 3'd1 : op_index_two_dim ? 3'd2 : 3'd3;

  // ****************************************
  // Conversion operand selection
  // ****************************************
  wire logic [63:0] cvt_val = (op_qtf || op_qte) ? {stk[3], stk[2], stk[1], stk[0]} :
                              (op_dtf || op_dte) ? {{32{stk[1][15]}}, stk[1], stk[0]} :
                              {{48{stk[0][15]}}, stk[0]};
  wire logic cvt_ext = op_ite || op_dte || op_qte;
  wire logic [63:0] cvt_fp;

  scibu_cvt u_cvt (
    .val(cvt_val),
    .ext(cvt_ext),
    .rnd(op_rnd),
    .fp(cvt_fp)
  );

  // ****************************************
  // Single-cycle instructions
  // ****************************************
  scibu_res_t alu_res;

  scibu_alu u_alu (
    .op(op),
    .stk(stk),
    .regs(regs),
    .cvt_fp(cvt_fp),
    .res(alu_res)
  );

  // ****************************************
  // Index state
  // ****************************************
  scibu_state_t state;
  scibu_state_t next_state;
  scibu_word_t [7:0] stk_q;
  logic [2:0] n_q;
  logic [2:0] i_q;
  scibu_word_t lo_q;
  scibu_word_t acc;

  wire logic idle = (state == SCIBU_ST_IDLE);
  wire logic take = start && idle;
  wire logic alu_take = take && !op_idx;
  wire logic idx_take = take && op_idx;
  wire logic ack_cnt = (state == SCIBU_ST_CNT) && mem_ack;
  wire logic ack_lo = (state == SCIBU_ST_LO) && mem_ack;
  wire logic ack_hi = (state == SCIBU_ST_HI) && mem_ack;

  // Subscript i sits one below A: B is the first dimension
  wire scibu_word_t sub = stk_q[3'(i_q + 3'd1)];
  wire logic too_low = $signed(sub) < $signed(lo_q);
  wire logic too_high = $signed(sub) > $signed(mem_rdata);
  wire logic out_of_bounds = too_low || too_high;
  wire logic last_dim = (3'(i_q + 3'd1) == n_q);
  wire scibu_word_t span = 16'(mem_rdata - lo_q + 16'h0001);
  // Row-major offset; wraps at 16 bits like the rest of the word datapath
  wire scibu_word_t next_acc = 16'(acc * span) + 16'(sub - lo_q);
  wire logic cnt_ok = (mem_rdata != 16'h0000) && (mem_rdata <= 16'(MAX_DIMS));

  wire logic fin_bad_cnt = ack_cnt && !cnt_ok;
  wire logic fin_oob = ack_hi && out_of_bounds;
  wire logic fin_ok = ack_hi && !out_of_bounds && last_dim;
  wire logic idx_fin = fin_bad_cnt || fin_oob || fin_ok;
  wire logic [3:0] idx_pop = fin_bad_cnt ? 4'd1 : 4'({1'b0, n_q} + 4'd1);

  // ****************************************
  // Index result assembly
  // ****************************************
  scibu_res_t fin_res;

  always_comb begin
    fin_res = '0;
    fin_res.cc = SCIBU_CC_EQUAL;
    fin_res.pop_cnt = idx_pop; // [RULE_05] [RULE_06] [RULE_09]
    fin_res.ovf = fin_bad_cnt || fin_oob; // [RULE_07]
    fin_res.reg_we = fin_oob || fin_ok;
    fin_res.reg_sel = `SCIBU_IDX_REG;
    fin_res.reg_wdata = fin_oob ? sub : next_acc; // [RULE_07] [RULE_08]
    fin_res.cc_we = fin_oob;
    if (fin_oob) begin
      fin_res.cc = too_low ? SCIBU_CC_LESS : SCIBU_CC_GREATER; // [RULE_07]
    end
  end

  // ****************************************
  // Index sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      SCIBU_ST_IDLE: begin
        if (idx_take) begin
          next_state = op_idxn ? SCIBU_ST_CNT : SCIBU_ST_LO; // [RULE_09]
        end
      end
      SCIBU_ST_CNT: begin
        if (mem_ack) begin
          next_state = cnt_ok ? SCIBU_ST_LO : SCIBU_ST_IDLE;
        end
      end
      SCIBU_ST_LO: begin
        if (mem_ack) begin
          next_state = SCIBU_ST_HI;
        end
      end
      SCIBU_ST_HI: begin
        if (mem_ack) begin
          next_state = (out_of_bounds || last_dim) ? SCIBU_ST_IDLE : SCIBU_ST_LO;
        end
      end
      default: begin
        next_state = SCIBU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SCIBU_ST_IDLE;
      busy <= 1'b0;
      mem_req <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state != SCIBU_ST_IDLE);
      mem_req <= (next_state != SCIBU_ST_IDLE);
    end
  end

  // Table address walks one word per read; code space unless data form
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr <= 16'h0000;
      mem_code <= 1'b0;
    end else if (idx_take) begin
      mem_addr <= stk[0]; // [RULE_05]
      mem_code <= !op_index_n_dim_data; // [RULE_09]
    end else if (ack_cnt || ack_lo || ack_hi) begin
      mem_addr <= 16'(mem_addr + 16'h0001);
    end
  end

  // Operands are frozen at issue so the sequencer may move on meanwhile
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stk_q <= '0;
      n_q <= 3'd0;
    end else if (idx_take) begin
      stk_q <= stk;
      n_q <= fixed_dims; // [RULE_06]
    end else if (ack_cnt) begin
      n_q <= mem_rdata[2:0]; // [RULE_09]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q <= 16'h0000;
    end else if (ack_lo) begin
      lo_q <= mem_rdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      i_q <= 3'd0;
      acc <= 16'h0000;
    end else if (idx_take) begin
      i_q <= 3'd0;
      acc <= 16'h0000;
    end else if (ack_hi && !out_of_bounds) begin
      i_q <= 3'(i_q + 3'd1);
      acc <= next_acc; // [RULE_08]
    end
  end

  // ****************************************
  // Completion registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      res <= '0;
    end else begin
      done <= alu_take || idx_fin;
      if (alu_take) begin
        res <= alu_res;
      end else if (idx_fin) begin
        res <= fin_res;
      end
    end
  end

endmodule

`default_nettype wire

/* sim/scibu_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none

module scibu_mem_model
  import scibu_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Read port
  input wire logic mem_req,
  input wire logic mem_code,
  input wire scibu_word_t mem_addr,
  input wire logic [3:0] wait_cycles,
  output logic mem_ack,
  output scibu_word_t mem_rdata
);
  scibu_word_t code_mem [0:63];
  scibu_word_t data_mem [0:63];
  logic [3:0] cnt;
  scibu_word_t word_sel;

  assign word_sel = mem_code ? code_mem[mem_addr[5:0]] : data_mem[mem_addr[5:0]];

  // Data toggles outside an ack to expose stale samples
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_req && !mem_ack && cnt >= wait_cycles) begin
      mem_ack <= 1'b1;
      mem_rdata <= word_sel;
      cnt <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

/* sim/scibu_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "scibu_consts.svh"

module scibu_props
  import scibu_pkg::*;
#(
  parameter int MAX_DIMS = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sequencer side
  input wire logic start,
  input wire logic [15:0] op,
  input wire scibu_word_t [7:0] stk,
  input wire scibu_word_t [7:0] regs,
  input wire logic busy,
  input wire logic done,
  input wire scibu_res_t res,
  // Table port
  input wire logic mem_req,
  input wire logic mem_code,
  input wire scibu_word_t mem_addr,
  input wire logic mem_ack,
  input wire scibu_word_t mem_rdata
);
  wire logic take = start && !busy;
  wire logic code_op = op == `SCIBU_OP_INDEX_ONE_DIM || op == `SCIBU_OP_INDEX_TWO_DIM ||
    op == `SCIBU_OP_INDEX_THREE_DIM || op == `SCIBU_OP_IDXN_CODE;
  wire logic is_idx = code_op || op == `SCIBU_OP_IDXN_DATA;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_take_idx;
    take && is_idx;
  endsequence
  sequence s_read_wait;
    mem_req && !mem_ack;
  endsequence

  a_single_cycle_ans: assert property (take && !is_idx |=> done && !busy)
    else $error("no one-cycle done");
  a_idx_first_read: assert property (s_take_idx |=> busy && mem_req &&
    mem_addr == $past(stk[0]) && mem_code == $past(code_op))
    else $error("bad first read");
  a_req_holds: assert property (s_read_wait |=> mem_req && $stable(mem_addr) && $stable(mem_code))
    else $error("request moved before ack");
  a_addr_steps: assert property (mem_req && mem_ack |=>
    !mem_req || mem_addr == $past(mem_addr) + 16'h0001)
    else $error("address not stepped");
  a_idx_bounded: assert property (s_take_idx |-> ##[1:200] done)
    else $error("index hung");
  a_idx_reg_seven: assert property (done && $past(busy) && res.reg_we |->
    res.reg_sel == 3'h7)
    else $error("index result not in R7");
  a_swap_words: assert property (take && op == `SCIBU_OP_SWAP_W |=>
    res.word[0] == $past(stk[1]) && res.word[1] == $past(stk[0]) && res.cc_we)
    else $error("word swap wrong");
  a_not_word: assert property (take && op == `SCIBU_OP_NOT |=>
    res.word[0] == ~$past(stk[0]) && res.pop_cnt == 4'h1)
    else $error("inversion wrong");
  a_merge_field: assert property (take && op == `SCIBU_OP_MERGE |=>
    res.word[0] == (($past(stk[1]) & $past(stk[2])) | (~$past(stk[1]) & $past(stk[0]))))
    else $error("field merge wrong");
  a_busy_no_done: assert property (busy && mem_req |-> !done)
    else $error("done during read");
endmodule
`default_nettype wire

/* sim/scibu_top_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end

module scibu_top_test
  import scibu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [15:0] op = 16'h0;
  scibu_word_t [7:0] stk = '0;
  scibu_word_t [7:0] regs = '0;
  logic busy, done, mem_req, mem_code, mem_ack;
  scibu_res_t res;
  scibu_word_t mem_addr, mem_rdata;
  logic [3:0] wait_cycles = 4'h0;
  int n_fail = 0;
  int n_tests = 0;
  logic [22:0] cv [0:7] = '{{16'h00c6, 7'h12}, {16'h00d6, 7'h12}, {16'h00d4, 7'h22},
    {16'h00d8, 7'h22}, {16'h00da, 7'h0c}, {16'h00dc, 7'h14}, {16'h00de, 7'h24},
    {16'h00dd, 7'h24}};
  logic [31:0] im [0:3] = '{32'h080f_123f, 32'h090f_1f34, 32'h0cf0_1230, 32'h0e8f_0234};
  scibu_word_t bx [0:2] = '{16'h3030, 16'hfcfc, 16'hcccc};
  scibu_word_t ct [0:12] = '{16'h2, 16'h9, 16'h0, 16'h3, 16'h1, 16'h4, 16'h0, 16'h1,
    16'h2, 16'h0, 16'h3, 16'h1, 16'h4};

  scibu_top #(.MAX_DIMS(7)) u_dut (.ref_clk, .rst_n, .start, .op, .stk, .regs, .busy,
    .done, .res, .mem_req, .mem_code, .mem_addr, .mem_ack, .mem_rdata);
  scibu_mem_model u_mem (.ref_clk, .rst_n, .mem_req, .mem_code, .mem_addr, .wait_cycles,
    .mem_ack, .mem_rdata);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic run(input logic [15:0] o, input scibu_word_t a = '0, b = '0, c = '0,
    d = '0);
    @(posedge ref_clk);
    #1;
    op = o;
    stk[3:0] = {d, c, b, a};
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    for (int i = 0; i < 100 && done !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK(done, 1'b1)
  endtask

  task automatic chk3(input scibu_word_t w, input logic [3:0] p, input logic [2:0] q);
    `CHK(res.word[0], w)
    `CHK(res.pop_cnt, p)
    `CHK(res.push_cnt, q)
  endtask

  task automatic chkr(input logic [2:0] s, input scibu_word_t w, input logic [3:0] p);
    `CHK(res.reg_we, 1'b1)
    `CHK(res.reg_sel, s)
    `CHK(res.reg_wdata, w)
    `CHK(res.pop_cnt, p)
  endtask

  // Run needs under a thousand cycles
  initial begin
    #100000;
    n_fail++;
    summarize();
  end

  initial begin
    regs[5] = 16'h8000;
    for (int k = 0; k < 13; k++) begin
      u_mem.code_mem[16 + k] = ct[k];
    end
    u_mem.data_mem[24] = 16'h1;
    u_mem.data_mem[25] = 16'h0;
    u_mem.data_mem[26] = 16'h7;
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // ****************
    // Stack moves
    // ****************
    run(16'h0004, 16'h8001, 16'h0002);
    chk3(16'h0002, 4'h2, 3'h2);
    `CHK(res.cc, SCIBU_CC_GREATER)
    run(16'h0005, 16'h0001, 16'h0002, 16'h0003, 16'h8000);
    chk3(16'h0003, 4'h4, 3'h4);
    `CHK({res.word[3], res.word[1]}, 32'h0002_8000)
    `CHK(res.cc, SCIBU_CC_LESS)
    run(16'h0006, 16'h0000, 16'h0001);
    `CHK({1'b0, res.push_cnt} - res.pop_cnt, 4'h2)
    `CHK({res.word[1], res.word[0]}, 32'h0001_0000)
    `CHK(res.cc, SCIBU_CC_GREATER)
    run(16'h004b, 16'h4321);
    chkr(3'h3, 16'h4321, 4'h1);
    run(16'h0053, 16'h4321);
    chkr(3'h3, 16'h4321, 4'h0);
    run(16'h005d);
    chk3(16'h8000, 4'h0, 3'h1);
    `CHK(res.cc, SCIBU_CC_LESS)
    run(16'h8005);
    chk3(16'h0005, 4'h0, 3'h1);
    run(16'h8405);
    chkr(3'h2, 16'h0005, 4'h0);
    run(16'h0a80);
    `CHK(res.word[0], 16'h80ff)
    $display("test stack moves done");
    // ****************
    // Boolean
    // ****************
    for (int k = 0; k < 3; k++) begin
      run(16'h0008 + k[15:0], 16'hf0f0, 16'h3c3c);
      chk3(bx[k], 4'h2, 3'h1);
      `CHK(res.cc, (k == 0) ? SCIBU_CC_GREATER : SCIBU_CC_LESS)
    end
    run(16'h000b, 16'hffff);
    chk3(16'h0000, 4'h1, 3'h1);
    `CHK(res.cc, SCIBU_CC_EQUAL)
    run(16'h000c, 16'h1234, 16'h00ff, 16'habcd);
    chk3(16'h12cd, 4'h3, 3'h1);
    for (int k = 0; k < 4; k++) begin
      run(im[k][31:16], 16'h1234);
      `CHK(res.word[0], im[k][15:0])
    end
    $display("test boolean done");
    // ****************
    // Conversions
    // ****************
    for (int k = 0; k < 8; k++) begin
      run(cv[k][22:7], 16'h0002);
      chk3(16'h0101, cv[k][6:3], cv[k][2:0]);
      `CHK(res.word[1], 16'h0000)
    end
    run(16'h00c6, 16'hffff, 16'h01ff);
    `CHK({res.word[1], res.word[0]}, 32'h7fff_ff18)
    run(16'h00d6, 16'hffff, 16'h01ff);
    `CHK({res.word[1], res.word[0]}, 32'h0000_0119)
    run(16'h00d4, 16'hffff, 16'hffff, 16'hffff, 16'hffff);
    `CHK({res.word[1], res.word[0]}, 32'h8000_0100)
    $display("test conversions done");
    // ****************
    // Index
    // ****************
    run(16'h00e4, 16'h0010, 16'h0005);
    chkr(3'h7, 16'h0003, 4'h2);
    `CHK(res.ovf, 1'b0)
    run(16'h00e4, 16'h0010, 16'h0001);
    chkr(3'h7, 16'h0001, 4'h2);
    `CHK({res.ovf, res.cc}, {1'b1, SCIBU_CC_LESS})
    run(16'h00e4, 16'h0010, 16'h000a);
    `CHK({res.ovf, res.cc, res.reg_wdata}, {1'b1, SCIBU_CC_GREATER, 16'h000a})
    run(16'h00e5, 16'h0012, 16'h0002, 16'h0003);
    chkr(3'h7, 16'h000a, 4'h3);
    run(16'h00e6, 16'h0012, 16'h0002, 16'h0003, 16'h0001);
    chkr(3'h7, 16'h0015, 4'h4);
    wait_cycles = 4'h3;
    run(16'h00e7, 16'h0018, 16'h0002, 16'h0003);
    chkr(3'h7, 16'h000a, 4'h3);
    run(16'h00cf, 16'h0018, 16'h0002, 16'h0003);
    chkr(3'h7, 16'h0002, 4'h2);
    run(16'h00cf, 16'h0019);
    `CHK({res.ovf, res.reg_we, res.pop_cnt}, 6'h21)
    $display("test index done");
    summarize();
  end
endmodule

bind scibu_top scibu_props #(.MAX_DIMS(MAX_DIMS)) u_props (.ref_clk, .rst_n, .start, .op,
  .stk, .regs, .busy, .done, .res, .mem_req, .mem_code, .mem_addr, .mem_ack, .mem_rdata);
`default_nettype wire
